// >>> lsp_drive_levels.sv
`timescale 1ns/1ns
module lsp_drive_levels (
  input  wire logic                 drive,
  input  wire logic [1:0]           mux,
  input  wire logic                 bias,
  input  wire logic                 phase,
  input  wire logic [1:0]           com,
  input  wire logic [47:0]          row,
  output lsp_pkg::lsp_seg_lvl_t     segLvl,
  output lsp_pkg::lsp_com_lvl_t     comLvl
);
  // phase flips every level to its mirror but the bias-mode unselected common and unused or idle pins,
  // so each pixel averages to zero only with bias clear or static drive
  function automatic logic [1:0] pick(logic ph, logic [1:0] a);
    pick = ph ? (lsp_pkg::LVL_MAX - a) : a;
  endfunction

  logic multi;
  assign multi = mux != lsp_pkg::LSP_MUX_STATIC;

  for (genvar c = 0; c < lsp_pkg::NUM_COMS; c++) begin : g_com
    always_comb begin
      if (!drive || 2'(c) > mux) begin
        comLvl[c] = lsp_pkg::LVL_MIN;
      end else if (2'(c) == com) begin
        comLvl[c] = pick(phase, lsp_pkg::LVL_MAX);
      end else if (bias) begin
        comLvl[c] = lsp_pkg::LVL_LOW;
      end else begin
        comLvl[c] = pick(phase, lsp_pkg::LVL_LOW);
      end
    end
  end

  for (genvar g = 0; g < lsp_pkg::NUM_SEGS; g++) begin : g_seg
    always_comb begin
      if (!drive) begin
        segLvl[g] = lsp_pkg::LVL_MIN;
      end else if (row[g]) begin
        segLvl[g] = pick(phase, lsp_pkg::LVL_MIN);
      end else if (!multi || bias) begin
        segLvl[g] = pick(phase, lsp_pkg::LVL_MAX);
      end else begin
        segLvl[g] = pick(phase, lsp_pkg::LVL_HIGH);
      end
    end
  end
endmodule

// >>> lsp_frame_clock.sv
`timescale 1ns/1ns
module lsp_frame_clock #(
  parameter int SYS_DIV = lsp_pkg::SYS_DIV_DEFAULT,
  parameter int OSC_DIV = lsp_pkg::OSC_DIV_DEFAULT
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] srcSel,
  input  wire logic       timerOscInput,
  input  wire logic       internalRcOsc,
  output logic            srcTick
);
  if (SYS_DIV < 2 || SYS_DIV > (1 << lsp_pkg::DIV_CNT_W) ||
      OSC_DIV < 2 || OSC_DIV > (1 << lsp_pkg::OSC_CNT_W)) begin
    $error("lsp_frame_clock: divider out of range");
  end

  lsp_pkg::lsp_div_s s_reg;
  lsp_pkg::lsp_div_s s_next;
  logic              srcEdge;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.tmrPrev = timerOscInput;
    s_next.rcPrev = internalRcOsc;
    case (srcSel)
      lsp_pkg::LSP_SRC_SYS: srcEdge = 1'b1;
      lsp_pkg::LSP_SRC_TMR: srcEdge = timerOscInput & ~s_reg.tmrPrev;
      default:              srcEdge = internalRcOsc & ~s_reg.rcPrev;
    endcase
    // counters hold while stopped so a wake resumes mid-slot
    if (run && srcEdge) begin
      if (srcSel == lsp_pkg::LSP_SRC_SYS) begin
        if (s_reg.sysCnt == lsp_pkg::DIV_CNT_W'(SYS_DIV - 1)) begin
          s_next.sysCnt = '0;
          s_next.tick = 1'b1;
        end else begin
          s_next.sysCnt = s_reg.sysCnt + 1'b1;
        end
      end else if (s_reg.oscCnt == lsp_pkg::OSC_CNT_W'(OSC_DIV - 1)) begin
        s_next.oscCnt = '0;
        s_next.tick = 1'b1;
      end else begin
        s_next.oscCnt = s_reg.oscCnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign srcTick = s_reg.tick;
endmodule

// >>> lsp_panel_driver.sv
`timescale 1ns/1ns
module lsp_panel_driver #(
  parameter int SYS_DIV = lsp_pkg::SYS_DIV_DEFAULT,
  parameter int OSC_DIV = lsp_pkg::OSC_DIV_DEFAULT
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire lsp_pkg::lsp_bus_s regReq,
  output logic [7:0]             regRdata,
  input  wire logic              sleepReq,
  input  wire logic              timerOscInput,
  input  wire logic              internalRcOsc,
  output lsp_pkg::lsp_seg_lvl_t  segLevel,
  output lsp_pkg::lsp_com_lvl_t  comLevel,
  output logic [47:0]            segDrive,
  output logic [3:0]             comDrive,
  output logic                   frameIrq,
  output logic                   moduleActive
);
  lsp_pkg::lsp_core_s    s;
  lsp_pkg::lsp_core_s    n;
  logic                  stopped;
  logic                  running;
  logic                  srcTick;
  logic                  slotWrap;
  logic                  lastSlot;
  logic                  typeBMulti;
  logic                  phase;
  logic                  werrSet;
  logic [15:0]           slotLen;
  logic [1:0]            lastCom;
  lsp_pkg::lsp_seg_lvl_t segWave;
  lsp_pkg::lsp_com_lvl_t comWave;

  function automatic logic isPix(logic [5:0] a);
    isPix = a < lsp_pkg::ADDR_SEGEN_BASE;
  endfunction

  function automatic logic isSeg(logic [5:0] a);
    isSeg = a >= lsp_pkg::ADDR_SEGEN_BASE && a < lsp_pkg::ADDR_CONTROL;
  endfunction

  function automatic logic [2:0] segIdx(logic [5:0] a);
    logic [5:0] d;
    d = a - lsp_pkg::ADDR_SEGEN_BASE;
    segIdx = d[2:0];
  endfunction

  // common 0 is a dedicated pin, 1..3 are borrowed port pins
  function automatic logic [3:0] comPins(logic [1:0] m);
    comPins = {m == lsp_pkg::LSP_MUX_QUARTER,
               m >= lsp_pkg::LSP_MUX_THIRD,
               m != lsp_pkg::LSP_MUX_STATIC,
               1'b1};
  endfunction

  function automatic logic [47:0] rowFor(
    logic [lsp_pkg::NUM_PIX_REGS-1:0][7:0] p, logic [1:0] c);
    rowFor = p[c*lsp_pkg::REGS_PER_COM +: lsp_pkg::REGS_PER_COM];
  endfunction

  // slot = k*(P+1) source ticks, k = 4,2,1,1; the frame is mux+1 slots
  function automatic logic [15:0] slotLength(logic [1:0] m,
                                             logic [3:0] p);
    logic [15:0] base;
    base = {12'h000, p} + 16'h0001;
    case (m)
      lsp_pkg::LSP_MUX_STATIC:
        slotLength = base << lsp_pkg::STATIC_SLOT_SHIFT;
      lsp_pkg::LSP_MUX_HALF:
        slotLength = base << lsp_pkg::HALF_SLOT_SHIFT;
      default:
        slotLength = base;
    endcase
  endfunction

  lsp_frame_clock #(
    .SYS_DIV (SYS_DIV),
    .OSC_DIV (OSC_DIV)
  ) u_clock (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .run           (running),
    .srcSel        (s.src),
    .timerOscInput (timerOscInput),
    .internalRcOsc (internalRcOsc),
    .srcTick       (srcTick)
  );

  lsp_drive_levels u_levels (
    .drive  (running),
    .mux    (s.mux),
    .bias   (s.bias),
    .phase  (phase),
    .com    (s.com),
    .row    (s.row),
    .segLvl (segWave),
    .comLvl (comWave)
  );

  // the system clock source cannot run in sleep whatever the halt bit
  assign stopped = sleepReq &&
    (s.sleepHalt || s.src == lsp_pkg::LSP_SRC_SYS);
  assign running = s.en && !stopped;
  assign slotLen = slotLength(s.mux, s.lp);
  assign lastCom = s.mux;
  assign lastSlot = s.com == lastCom;
  assign slotWrap = running && srcTick &&
                    s.preCnt == slotLen - 16'h0001;
  assign typeBMulti = s.waveform_type_sel && s.mux != lsp_pkg::LSP_MUX_STATIC;
  // type-A flips halfway through each slot of two or more ticks (never in a one-tick slot), type-B once per frame
  assign phase = s.waveform_type_sel ? s.parity
               : ({s.preCnt, 1'b0} >= {1'b0, slotLen});

  always_comb begin
    n = s;
    werrSet = 1'b0;
    n.rdata = '0;
    if (regReq.rd) begin
      if (isPix(regReq.addr)) begin
        n.rdata = s.pix[regReq.addr[4:0]];
      end else if (isSeg(regReq.addr)) begin
        n.rdata = s.segEn[segIdx(regReq.addr)];
      end else begin
        case (regReq.addr)
          lsp_pkg::ADDR_CONTROL:
            n.rdata = {s.en, s.sleepHalt, s.write_fail_flag, 1'b0,
                       s.src, s.mux};
          lsp_pkg::ADDR_PHASE:
            n.rdata = {s.waveform_type_sel, s.bias, s.active, s.wa, s.lp};
          lsp_pkg::ADDR_STATUS:
            n.rdata = {7'h00, s.frameFlag};
          default:
            n.rdata = '0;
        endcase
      end
    end
    if (regReq.wr) begin
      if (isPix(regReq.addr)) begin
        if (s.wa) begin
          n.pix[regReq.addr[4:0]] = regReq.wdata;
        end else begin
          werrSet = 1'b1;
        end
      end else if (isSeg(regReq.addr)) begin
        n.segEn[segIdx(regReq.addr)] = regReq.wdata;
      end else begin
        case (regReq.addr)
          lsp_pkg::ADDR_CONTROL: begin
            n.en = regReq.wdata[lsp_pkg::CTL_EN_BIT];
            n.sleepHalt = regReq.wdata[lsp_pkg::CTL_SLEEP_BIT];
            n.write_fail_flag = s.write_fail_flag & regReq.wdata[lsp_pkg::CTL_WRITE_FAIL_FLAG_BIT];
            n.src = regReq.wdata[lsp_pkg::CTL_CS_LSB +: 2];
            n.mux = regReq.wdata[lsp_pkg::CTL_MUX_LSB +: 2];
          end
          lsp_pkg::ADDR_PHASE: begin
            n.waveform_type_sel = regReq.wdata[lsp_pkg::PH_WFT_BIT];
            n.bias = regReq.wdata[lsp_pkg::PH_BIAS_BIT];
            n.lp = regReq.wdata[lsp_pkg::PH_LP_LSB +: 4];
          end
          lsp_pkg::ADDR_STATUS: begin
            if (regReq.wdata[lsp_pkg::ST_FRAME_BIT]) begin
              n.frameFlag = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (!s.en) begin
      n.preCnt = '0;
      n.com = '0;
      n.parity = 1'b0;
      n.row = rowFor(s.pix, 2'b00);
    end else if (running && srcTick) begin
      if (slotWrap) begin
        n.preCnt = '0;
        // fetch the row of the next common as its slot opens
        if (lastSlot) begin
          n.com = '0;
          n.parity = ~s.parity;
          n.row = rowFor(s.pix, 2'b00);
        end else begin
          n.com = s.com + 2'b01;
          n.row = rowFor(s.pix, s.com + 2'b01);
        end
        // last row fetched in the odd frame of the pair
        if (typeBMulti && s.parity &&
            s.com + 2'b01 == lastCom) begin
          n.frameFlag = 1'b1;
        end
      end else begin
        n.preCnt = s.preCnt + 16'h0001;
      end
    end
    // a live change of mux or prescale can shrink the slot under the
    // count; restart the slot so the prescaler never runs past it
    if (n.preCnt >= slotLength(n.mux, n.lp)) begin
      n.preCnt = '0;
    end
    if (werrSet) begin
      n.write_fail_flag = 1'b1;
    end
    // window runs from the last fetch up to the next frame's first
    n.wa = !sleepReq && (!n.en || (n.com == lastCom &&
           (!typeBMulti || n.parity)));
    n.active = running;
    n.segLvl = segWave;
    n.comLvl = comWave;
    n.segDrv = s.segEn;
    n.comDrv = comPins(s.mux);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= lsp_pkg::CORE_RESET;
    end else begin
      s <= n;
    end
  end

  assign regRdata = s.rdata;
  assign segLevel = s.segLvl;
  assign comLevel = s.comLvl;
  assign segDrive = s.segDrv;
  assign comDrive = s.comDrv;
  assign frameIrq = s.frameFlag;
  assign moduleActive = s.active;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_pixel_write_kept: assert property (
    regReq.wr && isPix(regReq.addr) && s.wa
    |=> s.pix[$past(regReq.addr[4:0])] == $past(regReq.wdata))
    else $error("pixel write not stored");

  a_blocked_write_err: assert property (
    regReq.wr && isPix(regReq.addr) && !s.wa
    |=> s.write_fail_flag && s.pix == $past(s.pix))
    else $error("blocked pixel write mishandled");

  a_flag_only_typeb: assert property (
    $rose(s.frameFlag) |-> $past(s.waveform_type_sel) &&
      $past(s.mux) != lsp_pkg::LSP_MUX_STATIC && $past(s.parity))
    else $error("frame flag in wrong mode");

  a_flag_sticky: assert property (
    s.frameFlag && !(regReq.wr && regReq.addr == lsp_pkg::ADDR_STATUS)
    |=> s.frameFlag)
    else $error("frame flag dropped");

  a_stop_min_drive: assert property (
    s.en && stopped ##1 stopped |=> s.comLvl == '0 && s.segLvl == '0)
    else $error("stopped block still drives");

  a_sys_sleep_stop: assert property (
    sleepReq && s.src == lsp_pkg::LSP_SRC_SYS |=> !s.active)
    else $error("system clock source ran in sleep");

  a_com_pin_map: assert property (
    s.mux == $past(s.mux) |=> s.comDrv == comPins($past(s.mux)))
    else $error("common pin map wrong");

  a_frame_start_common_line_zero: assert property (
    slotWrap && lastSlot |=> s.com == '0 && s.parity != $past(s.parity))
    else $error("frame did not restart at common 0");

  a_prescale_bound: assert property (
    running && s.lp == $past(s.lp) && s.mux == $past(s.mux)
    |-> s.preCnt < slotLen)
    else $error("prescaler ran past slot");

  a_control_readback: assert property (
    regReq.rd && regReq.addr == lsp_pkg::ADDR_CONTROL
    |=> regRdata[lsp_pkg::CTL_CS_LSB +: 2] == $past(s.src))
    else $error("control read wrong");

  c_frame_flag: cover property ($rose(s.frameFlag));
  c_write_error: cover property ($rose(s.write_fail_flag));
  c_sleep_stop: cover property (s.active ##1 stopped);
endmodule

// >>> lsp_panel_model.sv
`timescale 1ns/1ns
module lsp_panel_model (
  input  wire logic                  sys_clk,
  input  wire logic                  clearAcc,
  input  wire lsp_pkg::lsp_seg_lvl_t segLevel,
  input  wire lsp_pkg::lsp_com_lvl_t comLevel
);
  // passive glass: integrates the voltage across every pixel so the bench
  // can judge dc balance and dark/clear rms from the pins alone
  int dcSum [lsp_pkg::NUM_SEGS][lsp_pkg::NUM_COMS];
  int sqSum [lsp_pkg::NUM_SEGS][lsp_pkg::NUM_COMS];

  always @(posedge sys_clk) begin
    for (int s = 0; s < lsp_pkg::NUM_SEGS; s++) begin
      for (int c = 0; c < lsp_pkg::NUM_COMS; c++) begin
        int d;
        d = int'(comLevel[c]) - int'(segLevel[s]);
        if (clearAcc) begin
          dcSum[s][c] = 0;
          sqSum[s][c] = 0;
        end else begin
          dcSum[s][c] += d;
          sqSum[s][c] += d * d;
        end
      end
    end
  end
endmodule

// >>> lsp_pkg.sv
package lsp_pkg;
  localparam int NUM_PIX_REGS    = 24;
  localparam int REGS_PER_COM    = 6;
  localparam int NUM_SEG_REGS    = 6;
  localparam int NUM_SEGS        = 48;
  localparam int NUM_COMS        = 4;
  localparam int SYS_DIV_DEFAULT = 8192;
  localparam int OSC_DIV_DEFAULT = 32;
  localparam int DIV_CNT_W       = 16;
  localparam int OSC_CNT_W       = 5;

  localparam logic [5:0] ADDR_SEGEN_BASE = 6'h18;
  localparam logic [5:0] ADDR_CONTROL    = 6'h1E;
  localparam logic [5:0] ADDR_PHASE      = 6'h1F;
  localparam logic [5:0] ADDR_STATUS     = 6'h20;

  localparam int CTL_EN_BIT    = 7;
  localparam int CTL_SLEEP_BIT = 6;
  localparam int CTL_WRITE_FAIL_FLAG_BIT  = 5;
  localparam int CTL_CS_LSB    = 2;
  localparam int CTL_MUX_LSB   = 0;
  localparam int PH_WFT_BIT    = 7;
  localparam int PH_BIAS_BIT   = 6;
  localparam int PH_LP_LSB     = 0;
  localparam int ST_FRAME_BIT  = 0;

  localparam int STATIC_SLOT_SHIFT = 2;
  localparam int HALF_SLOT_SHIFT   = 1;

  typedef enum logic [1:0] {
    LSP_SRC_SYS = 2'b00,
    LSP_SRC_TMR = 2'b01,
    LSP_SRC_RC  = 2'b10
  } lsp_src_e;

  typedef enum logic [1:0] {
    LSP_MUX_STATIC  = 2'b00,
    LSP_MUX_HALF    = 2'b01,
    LSP_MUX_THIRD   = 2'b10,
    LSP_MUX_QUARTER = 2'b11
  } lsp_mux_e;

  localparam logic [1:0] LVL_MIN  = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_MAX  = 2'h3;

  typedef logic [NUM_SEGS-1:0][1:0] lsp_seg_lvl_t;
  typedef logic [NUM_COMS-1:0][1:0] lsp_com_lvl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } lsp_bus_s;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] sysCnt;
    logic [OSC_CNT_W-1:0] oscCnt;
    logic                 tmrPrev;
    logic                 rcPrev;
    logic                 tick;
  } lsp_div_s;

  typedef struct packed {
    logic [NUM_PIX_REGS-1:0][7:0] pix;
    logic [NUM_SEG_REGS-1:0][7:0] segEn;
    logic                         en;
    logic                         sleepHalt;
    logic                         write_fail_flag;
    logic [1:0]                   src;
    logic [1:0]                   mux;
    logic                         waveform_type_sel;
    logic                         bias;
    logic [3:0]                   lp;
    logic                         frameFlag;
    logic [15:0]                  preCnt;
    logic [1:0]                   com;
    logic                         parity;
    logic [NUM_SEGS-1:0]          row;
    logic [7:0]                   rdata;
    lsp_seg_lvl_t                 segLvl;
    lsp_com_lvl_t                 comLvl;
    logic [NUM_SEGS-1:0]          segDrv;
    logic [NUM_COMS-1:0]          comDrv;
    logic                         active;
    logic                         wa;
  } lsp_core_s;

  localparam lsp_core_s CORE_RESET = '{wa: 1'b1, default: '0};
endpackage

// >>> tb_lsp_panel_driver.sv
`timescale 1ns/1ns
module tb_lsp_panel_driver;
  localparam int         SYS_DIV = 4;
  localparam int         OSC_DIV = 2;
  localparam logic [5:0] CTL     = lsp_pkg::ADDR_CONTROL;
  localparam logic [5:0] PHS     = lsp_pkg::ADDR_PHASE;
  localparam logic [5:0] STS     = lsp_pkg::ADDR_STATUS;

  logic                  sys_clk       = 1'h0;
  logic                  rst_n         = 1'h0;
  lsp_pkg::lsp_bus_s     regReq        = '0;
  logic [7:0]            regRdata;
  logic                  sleepReq      = 1'h0;
  logic                  timerOscInput = 1'h0;
  logic                  internalRcOsc = 1'h0;
  lsp_pkg::lsp_seg_lvl_t segLevel;
  lsp_pkg::lsp_com_lvl_t comLevel;
  logic [47:0]           segDrive;
  logic [3:0]            comDrive;
  logic                  frameIrq;
  logic                  moduleActive;
  logic                  clearAcc      = 1'h0;
  logic [1:0]            tmrDiv        = 2'h0;
  int                    nErrors       = 0;
  int                    nTests        = 0;
  int                    cyc           = 0;

  lsp_panel_driver #(.SYS_DIV(SYS_DIV), .OSC_DIV(OSC_DIV)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdata(regRdata), .sleepReq(sleepReq),
    .timerOscInput(timerOscInput), .internalRcOsc(internalRcOsc),
    .segLevel(segLevel), .comLevel(comLevel), .segDrive(segDrive),
    .comDrive(comDrive), .frameIrq(frameIrq),
    .moduleActive(moduleActive)
  );

  lsp_panel_model panel (
    .sys_clk(sys_clk), .clearAcc(clearAcc),
    .segLevel(segLevel), .comLevel(comLevel)
  );

  always #50 sys_clk = ~sys_clk;

  // timer rises every 6 cycles, rc every 4: tick periods 12 and 8
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    tmrDiv <= (tmrDiv == 2'h2) ? 2'h0 : tmrDiv + 2'h1;
    if (tmrDiv == 2'h2) begin
      timerOscInput <= ~timerOscInput;
    end
    if (cyc[0]) begin
      internalRcOsc <= ~internalRcOsc;
    end
    if (cyc == 20000) begin
      nErrors++;
      giveVerdict();
    end
  end

  task automatic giveVerdict;
    $display("errors=%0d tests=%0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic checkVal(input logic [95:0] got, input logic [95:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkNum(input int got, input int exp);
    nTests++;
    if (got != exp) begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [5:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    regReq <= '{wr: 1'h1, rd: 1'h0, addr: addr, wdata: data};
    @(posedge sys_clk);
    regReq <= '0;
  endtask

  task automatic expectReg(input logic [5:0] addr, input logic [7:0] exp);
    @(posedge sys_clk);
    regReq <= '{wr: 1'h0, rd: 1'h1, addr: addr, wdata: 8'h00};
    @(posedge sys_clk);
    regReq <= '0;
    #10;
    checkVal(96'(regRdata), 96'(exp));
  endtask

  task automatic waitIrq(input int limit);
    int n;
    n = 0;
    // let the edge that ended the last request settle first
    #1;
    while (frameIrq !== 1'h1 && n < limit) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    checkNum(int'(frameIrq === 1'h1), 1);
  endtask

  task automatic resetTest;
    for (int a = 0; a < 33; a++) begin
      expectReg(6'(a), (a == 31) ? 8'h10 : 8'h00);
    end
    regWrite(6'h30, 8'hFF);
    expectReg(6'h30, 8'h00);
    checkVal(96'(segDrive), 96'h0);
    checkVal(96'(comDrive), 96'h1);
  endtask

  task automatic pinTest;
    logic [47:0] exp;
    exp = '0;
    for (int k = 0; k < 6; k++) begin
      regWrite(lsp_pkg::ADDR_SEGEN_BASE + 6'(k), 8'(8'h03 << k));
      exp[8*k +: 8] = 8'(8'h03 << k);
    end
    @(posedge sys_clk);
    #1;
    checkVal(96'(segDrive), 96'(exp));
    for (int k = 0; k < 6; k++) begin
      regWrite(lsp_pkg::ADDR_SEGEN_BASE + 6'(k), 8'hFF);
    end
    for (int m = 0; m < 4; m++) begin
      regWrite(CTL, 8'(m));
      @(posedge sys_clk);
      #1;
      checkVal(96'(comDrive), 96'({m == 3, m >= 2, m >= 1, 1'h1}));
    end
  endtask

  // quarter drive, prescale 1: frame 32 cycles, window two frames
  task automatic pixelTest(input logic waveform_type_sel);
    regWrite(CTL, 8'h00);
    regWrite(6'h0D, 8'h04);
    regWrite(PHS, {waveform_type_sel, 7'h01});
    regWrite(CTL, 8'h83);
    repeat (96) @(posedge sys_clk);
    clearAcc <= 1'h1;
    @(posedge sys_clk);
    clearAcc <= 1'h0;
    repeat (64) @(posedge sys_clk);
    #1;
    checkNum(panel.dcSum[10][2], 0);
    checkNum(panel.dcSum[11][2], 0);
    checkNum(int'(panel.sqSum[10][2] > panel.sqSum[11][2]), 1);
    checkNum(int'(panel.sqSum[10][2] > panel.sqSum[10][1]), 1);
  endtask

  task automatic periodTest(input logic [1:0] src, input logic [1:0] mux,
                            input logic [3:0] lp, input int tick);
    int tA;
    int k;
    k = (mux == 2'h0) ? 4 : (mux == 2'h1) ? 2 : 1;
    regWrite(CTL, 8'h00);
    regWrite(PHS, {4'h8, lp});
    regWrite(CTL, {4'h8, src, mux});
    waitIrq(3000);
    regWrite(STS, 8'h01);
    waitIrq(3000);
    tA = cyc;
    regWrite(STS, 8'h01);
    waitIrq(3000);
    checkNum(cyc - tA, 2 * (int'(mux) + 1) * k * (int'(lp) + 1) * tick);
    repeat (10) @(posedge sys_clk);
    checkVal(96'(frameIrq), 96'h1);
  endtask

  task automatic noIrqTest(input logic waveform_type_sel, input logic [1:0] mux);
    int hits;
    hits = 0;
    regWrite(CTL, 8'h00);
    regWrite(PHS, {waveform_type_sel, 7'h00});
    regWrite(CTL, {6'h20, mux});
    regWrite(STS, 8'h01);
    repeat (2) @(posedge sys_clk);
    repeat (200) begin
      @(posedge sys_clk);
      #1;
      hits += int'(frameIrq !== 1'h0);
    end
    checkNum(hits, 0);
  endtask

  task automatic sleepCheck(input logic [7:0] ctl, input logic expAct);
    @(posedge sys_clk);
    sleepReq <= 1'h0;
    regWrite(CTL, ctl);
    repeat (40) @(posedge sys_clk);
    sleepReq <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    checkVal(96'(moduleActive), 96'(expAct));
    if (!expAct) begin
      checkVal(96'(segLevel), 96'h0);
      checkVal(96'(comLevel), 96'h0);
    end
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    resetTest();
    pinTest();
    pixelTest(1'h0);
    pixelTest(1'h1);
    periodTest(2'h0, 2'h1, 4'h2, SYS_DIV);
    periodTest(2'h0, 2'h3, 4'h0, SYS_DIV);
    periodTest(2'h0, 2'h2, 4'hF, SYS_DIV);
    periodTest(2'h1, 2'h1, 4'h0, 6 * OSC_DIV);
    periodTest(2'h2, 2'h1, 4'h0, 4 * OSC_DIV);
    periodTest(2'h3, 2'h1, 4'h1, 4 * OSC_DIV);
    noIrqTest(1'h0, 2'h1);
    noIrqTest(1'h1, 2'h0);
    regWrite(PHS, 8'h00);
    sleepCheck(8'hC9, 1'h0);
    sleepCheck(8'h81, 1'h0);
    sleepCheck(8'h89, 1'h1);
    expectReg(PHS, 8'h20);
    regWrite(6'h00, 8'hA5);
    expectReg(6'h00, 8'h00);
    expectReg(CTL, 8'hA9);
    @(posedge sys_clk);
    sleepReq <= 1'h0;
    regWrite(CTL, 8'h89);
    expectReg(CTL, 8'h89);
    giveVerdict();
  end
endmodule
